/* File: include/lpm_pkg.sv */
// constants, register map and carrier types of the low-power mode sequencer
// assumes a 50 MHz system clock; every register is one aligned 32-bit word
package lpm_pkg;
	// ============================================================
	// clock and time base
	localparam int CLK_HZ            = 50_000_000;
	localparam int CLK_PERIOD_NS     = 20;
	localparam int SUB_CLK_HZ        = 32_768;
	localparam int SUB_DIV_CYC       = CLK_HZ / SUB_CLK_HZ;
	localparam int CYCLE_LONG_NS     = 244_000;
	localparam int CYCLE_SHORT_NS    = 122_000;
	localparam int OSC_STABILIZE_NS  = 1_000_000;
	localparam int CYCLE_LONG_CYC    = (CYCLE_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CYCLE_SHORT_CYC   = (CYCLE_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OSC_STABILIZE_CYC = (OSC_STABILIZE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// interrupt frame lengths in sub-clock ticks, one per frame select code 0 to 2
	localparam int FRAME_TICKS_0     = 8;
	localparam int FRAME_TICKS_1     = 64;
	localparam int FRAME_TICKS_2     = 512;
	// ============================================================
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_TIMER_A_MODE = 8'h08;
	localparam logic [7:0] IDX_MISC         = 8'h0C;
	localparam logic [7:0] IDX_MODE_FLAGS   = 8'h20;
	localparam logic [7:0] IDX_RAM_FLAGS    = 8'h21;
	localparam logic [7:0] IDX_SYS_CLK_SEL  = 8'h29;
	localparam logic [7:0] IDX_STATUS       = 8'h3F;
	// field positions
	localparam int WATCH_SELECT_BIT  = 3;
	localparam int FRAME_SEL_LSB     = 0;
	localparam int LOW_SPEED_BIT     = 0;
	localparam int DIRECT_XFER_BIT   = 3;
	localparam int RAM_VALID_BIT     = 3;
	localparam int OSC_RANGE_BIT     = 1;
	localparam int CYCLE_SEL_BIT     = 2;
	localparam logic [3:0] REG_RESET = 4'h0;
	localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;
	// ============================================================
	// types
	typedef enum logic [2:0] {
		MODE_ACTIVE, MODE_STANDBY, MODE_STOP, MODE_WATCH,
		MODE_SUBACTIVE, MODE_DIRECT_WAIT, MODE_STABILIZE
	} power_mode_e;

	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
		logic        hready;
	} ahb_in_s;
endpackage

/* File: verilog/low_power_mode_sequencer.sv */
// power-mode sequencer: active, standby, stop, watch, subactive and the
// interrupt-frame time base, with an AHB-Lite register slave
// assumes instruction strobes and interrupt status come from the cpu core
// in the clk domain, and that pins are already synchronous to clk
//
// Overview of operation
// - subactive instruction cycle is 244 or 122 us by clock select bit 2
// - stop or standby in subactive goes to watch or active per flags
// - sub-clock drives timer A and external interrupt in watch and subactive
// - three interrupt frame lengths selected in the miscellaneous register
// - interrupt requests align to strobe, suppressed during transition to active
// - external falling edge is taken at the second strobe after it
// - timer A overflow and its request align to the strobe
// - low-speed clear plus direct-transfer set then stop reaches active
// - direct-transfer flag settable only in subactive, cleared in active
// - direct transition lasts over stabilization, under frame plus stabilization
// - leaving stop by reset or stop-cancel restarts at address zero
// - ram valid flag reads 0 after reset, 1 after stop-cancel
// - reset cancels every mode, stop-cancel acts only in stop
// - reset acts asynchronously whatever the state
// - stop or standby with interrupts off and one pending is a no-op
// - external pin sampled, falling edge when samples go high to low
// - edges with high or low under one frame can go undetected
// - wake from watch enters active if low-speed 0, else subactive
// - stop in active enters stop or watch per watch select bit
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
module low_power_mode_sequencer
	import lpm_pkg::*;
#(
	parameter int STAB_CYC  = OSC_STABILIZE_CYC,
	parameter int LONG_CYC  = CYCLE_LONG_CYC,
	parameter int SHORT_CYC = CYCLE_SHORT_CYC
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// register bus
	input  wire ahb_in_s     ahb_in,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// cpu core
	input  wire logic        stop_instr,
	input  wire logic        standby_instr,
	input  wire logic        global_interrupt_enable,
	input  wire logic        unmasked_irq_pending,
	// pins
	input  wire logic        ext_wake_interrupt_n,
	input  wire logic        stop_cancel_pin_n,
	// sequencer outputs
	output power_mode_e      power_mode,
	output logic             cpu_clk_en,
	output logic             instr_tick,
	output logic             cpu_restart,
	output logic             main_osc_en,
	output logic             timer_a_irq,
	output logic             ext_irq
);
	// ============================================================
	// state
	typedef struct packed {
		power_mode_e mode;
		logic [10:0] sub_div;
		logic        sub_tick;
		logic [9:0]  prescaler;
		logic        strobe;
		logic [7:0]  timer_a;
		logic        ext_prev;
		logic        ext_pend;
		logic [19:0] stab_cnt;
		logic [15:0] instr_cnt;
		logic [3:0]  timer_a_mode;
		logic [3:0]  misc;
		logic        low_speed_flag;
		logic        direct_transfer_flag;
		logic        ram_valid_flag;
		logic [3:0]  sys_clk_sel;
		logic        dp_valid;
		logic        dp_write;
		logic [7:0]  dp_idx;
		logic [31:0] rdata;
		logic        clk_en;
		logic        osc_en;
		logic        tick;
		logic        restart;
		logic        ta_irq;
		logic        ex_irq;
	} seq_s;

	seq_s        cur;
	seq_s        next_cur;
	logic [1:0]  rst_pipe;
	logic        rst_sync_n;
	logic [9:0]  frame_len;
	logic        instr_req;
	logic        instr_nop;
	logic        ta_event;
	logic        ex_event;
	logic        wake_event;
	logic        addr_phase;

	// ============================================================
	// reset release
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_pipe <= 2'h0;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end
	assign rst_sync_n = rst_pipe[1];

	function automatic logic [31:0] read_reg(input seq_s s, input logic [7:0] idx);
		read_reg = 32'h0;
		case (idx)
			IDX_TIMER_A_MODE: read_reg[3:0] = s.timer_a_mode;
			IDX_MISC:         read_reg[3:0] = s.misc;
			IDX_MODE_FLAGS: begin
				read_reg[LOW_SPEED_BIT]   = s.low_speed_flag;
				read_reg[DIRECT_XFER_BIT] = s.direct_transfer_flag;
			end
			IDX_RAM_FLAGS:    read_reg[RAM_VALID_BIT] = s.ram_valid_flag;
			IDX_SYS_CLK_SEL:  read_reg[3:0] = s.sys_clk_sel;
			IDX_STATUS:       read_reg[10:0] = {s.timer_a, s.mode};
			default:          read_reg = 32'h0;
		endcase
	endfunction

	// ============================================================
	// next state
	always_comb begin
		next_cur = cur;
		// frame select code 3 falls back to the longest frame
		case (cur.misc[FRAME_SEL_LSB +: 2])
			2'h0:    frame_len = 10'(FRAME_TICKS_0);
			2'h1:    frame_len = 10'(FRAME_TICKS_1);
			default: frame_len = 10'(FRAME_TICKS_2);
		endcase
		instr_req = stop_instr | standby_instr;
		instr_nop = !global_interrupt_enable && unmasked_irq_pending;
		addr_phase = ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready;

		// sub-clock enable and frame strobe, running in every mode but stop
		next_cur.sub_tick = 1'b0;
		next_cur.strobe   = 1'b0;
		if (cur.mode != MODE_STOP) begin
			if (cur.sub_div == 11'(SUB_DIV_CYC - 1)) begin
				next_cur.sub_div  = 11'h0;
				next_cur.sub_tick = 1'b1;
			end else begin
				next_cur.sub_div = cur.sub_div + 11'h1;
			end
			if (cur.sub_tick) begin
				if (cur.prescaler >= frame_len - 10'h1) begin
					next_cur.prescaler = 10'h0;
					next_cur.strobe    = 1'b1;
				end else begin
					next_cur.prescaler = cur.prescaler + 10'h1;
				end
			end
		end

		// timer A overflow and external edge, both taken on the strobe
		ta_event = 1'b0;
		ex_event = 1'b0;
		if (cur.strobe) begin
			next_cur.timer_a = cur.timer_a + 8'h1;
			ta_event = (cur.timer_a == 8'hFF);
			ex_event = cur.ext_pend;
			next_cur.ext_pend = cur.ext_prev && !ext_wake_interrupt_n;
			next_cur.ext_prev = ext_wake_interrupt_n;
		end
		wake_event = ta_event || ex_event;
		// requests are held back while the main oscillator is coming up
		next_cur.ta_irq = ta_event && cur.mode != MODE_DIRECT_WAIT && cur.mode != MODE_STABILIZE;
		next_cur.ex_irq = ex_event && cur.mode != MODE_DIRECT_WAIT && cur.mode != MODE_STABILIZE;

		// subactive instruction cycle
		next_cur.tick = 1'b0;
		if (cur.mode == MODE_SUBACTIVE) begin
			if (cur.instr_cnt >= 16'(cur.sys_clk_sel[CYCLE_SEL_BIT] ? SHORT_CYC - 1 : LONG_CYC - 1)) begin
				next_cur.instr_cnt = 16'h0;
				next_cur.tick      = 1'b1;
			end else begin
				next_cur.instr_cnt = cur.instr_cnt + 16'h1;
			end
		end else begin
			next_cur.instr_cnt = 16'h0;
		end

		// mode sequencing
		next_cur.restart = 1'b0;
		next_cur.stab_cnt = 20'h0;
		case (cur.mode)
			MODE_ACTIVE: begin
				if (instr_req && !instr_nop) begin
					if (standby_instr) begin
						next_cur.mode = MODE_STANDBY;
					end else if (cur.timer_a_mode[WATCH_SELECT_BIT]) begin
						next_cur.mode = MODE_WATCH;
					end else begin
						next_cur.mode = MODE_STOP;
					end
				end
			end
			MODE_STANDBY: begin
				if (unmasked_irq_pending || wake_event) begin
					next_cur.mode = MODE_ACTIVE;
				end
			end
			MODE_STOP: begin
				// stop-cancel is looked at in this state only
				if (!stop_cancel_pin_n) begin
					next_cur.mode           = MODE_STABILIZE;
					next_cur.ram_valid_flag = 1'b1;
					next_cur.restart        = 1'b1;
				end
			end
			MODE_WATCH: begin
				if (wake_event) begin
					next_cur.mode = cur.low_speed_flag ? MODE_SUBACTIVE : MODE_STABILIZE;
				end
			end
			MODE_SUBACTIVE: begin
				if (instr_req && !instr_nop) begin
					if (!cur.low_speed_flag && cur.direct_transfer_flag) begin
						next_cur.mode = MODE_DIRECT_WAIT;
					end else begin
						next_cur.mode = MODE_WATCH;
					end
				end
			end
			MODE_DIRECT_WAIT: begin
				// waiting for a frame boundary keeps the transfer under T plus stabilization
				if (cur.strobe) begin
					next_cur.mode = MODE_STABILIZE;
				end
			end
			MODE_STABILIZE: begin
				if (cur.stab_cnt == 20'(STAB_CYC - 1)) begin
					next_cur.mode = MODE_ACTIVE;
				end else begin
					next_cur.stab_cnt = cur.stab_cnt + 20'h1;
				end
			end
			default: next_cur.mode = MODE_ACTIVE;
		endcase

		// bus data phase
		if (cur.dp_valid && cur.dp_write) begin
			case (cur.dp_idx)
				IDX_TIMER_A_MODE: next_cur.timer_a_mode = ahb_in.hwdata[3:0];
				IDX_MISC:         next_cur.misc = ahb_in.hwdata[3:0];
				IDX_MODE_FLAGS: begin
					next_cur.low_speed_flag = ahb_in.hwdata[LOW_SPEED_BIT];
					if (cur.mode == MODE_SUBACTIVE) begin
						next_cur.direct_transfer_flag = ahb_in.hwdata[DIRECT_XFER_BIT];
					end
				end
				// a stop-cancel exit in the same cycle wins over a software clear
				IDX_RAM_FLAGS:    next_cur.ram_valid_flag = ahb_in.hwdata[RAM_VALID_BIT] || next_cur.restart;
				IDX_SYS_CLK_SEL:  next_cur.sys_clk_sel = ahb_in.hwdata[3:0];
				default: ;
			endcase
		end
		if (next_cur.mode == MODE_ACTIVE) begin
			next_cur.direct_transfer_flag = 1'b0;
		end
		next_cur.dp_valid = addr_phase;
		next_cur.dp_write = addr_phase && ahb_in.hwrite;
		next_cur.dp_idx   = addr_phase ? ahb_in.haddr[9:2] : cur.dp_idx;
		// read data comes from the post-write copy so a write then read sees new data
		next_cur.rdata    = (addr_phase && !ahb_in.hwrite) ? read_reg(next_cur, ahb_in.haddr[9:2]) : 32'h0;
		next_cur.clk_en   = next_cur.mode == MODE_ACTIVE || next_cur.mode == MODE_SUBACTIVE;
		next_cur.osc_en   = next_cur.mode == MODE_ACTIVE || next_cur.mode == MODE_STANDBY;
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			cur                      <= '0;
			cur.mode                 <= MODE_ACTIVE;
			cur.timer_a_mode         <= REG_RESET;
			cur.misc                 <= REG_RESET;
			cur.sys_clk_sel          <= REG_RESET;
			cur.ram_valid_flag       <= 1'b0;
			cur.ext_prev             <= 1'b1;
			cur.clk_en               <= 1'b1;
			cur.osc_en               <= 1'b1;
			cur.restart              <= 1'b1;
		end else begin
			cur <= next_cur;
		end
	end

	// ============================================================
	// outputs straight from the state register; hreadyout from the reset pipeline, hresp tied low
	assign power_mode  = cur.mode;
	assign cpu_clk_en  = cur.clk_en;
	assign instr_tick  = cur.tick;
	assign cpu_restart = cur.restart;
	assign timer_a_irq = cur.ta_irq;
	assign ext_irq     = cur.ex_irq;
	assign hrdata      = cur.rdata;
	assign hreadyout   = rst_pipe[1];
	assign hresp       = 1'b0;
	assign main_osc_en = cur.osc_en;

	// ============================================================
	// checks
	property p_direct_transfer_flag_active;
		@(posedge clk) disable iff (!rst_sync_n)
		cur.mode == MODE_ACTIVE |-> !cur.direct_transfer_flag;
	endproperty
	a_direct_transfer_flag_active: assert property (p_direct_transfer_flag_active) else $error("direct flag set in active");

	property p_clk_gate;
		@(posedge clk) disable iff (!rst_sync_n)
		(cur.mode == MODE_STANDBY || cur.mode == MODE_WATCH || cur.mode == MODE_STOP) |-> !cpu_clk_en;
	endproperty
	a_clk_gate: assert property (p_clk_gate) else $error("execution clock on in sleep mode");

	property p_stop_cancel;
		@(posedge clk) disable iff (!rst_sync_n)
		cur.mode == MODE_STOP && !stop_cancel_pin_n |=> cur.mode == MODE_STABILIZE && cur.ram_valid_flag && cpu_restart;
	endproperty
	a_stop_cancel: assert property (p_stop_cancel) else $error("stop cancel not taken");

	property p_stop_cancel_pin_ignored;
		@(posedge clk) disable iff (!rst_sync_n)
		cur.mode == MODE_ACTIVE && !stop_cancel_pin_n && !stop_instr && !standby_instr |=> cur.mode == MODE_ACTIVE;
	endproperty
	a_stop_cancel_pin_ignored: assert property (p_stop_cancel_pin_ignored) else $error("stop cancel acted outside stop");

	property p_nop;
		@(posedge clk) disable iff (!rst_sync_n)
		cur.mode == MODE_ACTIVE && instr_req && !global_interrupt_enable && unmasked_irq_pending |=> cur.mode == MODE_ACTIVE;
	endproperty
	a_nop: assert property (p_nop) else $error("sleep taken with pending interrupt");

	property p_watch_sel;
		@(posedge clk) disable iff (!rst_sync_n)
		cur.mode == MODE_ACTIVE && stop_instr && !standby_instr && !instr_nop
			|=> cur.mode == ($past(cur.timer_a_mode[WATCH_SELECT_BIT]) ? MODE_WATCH : MODE_STOP);
	endproperty
	a_watch_sel: assert property (p_watch_sel) else $error("wrong mode after stop");

	property p_irq_strobe;
		@(posedge clk) disable iff (!rst_sync_n)
		(timer_a_irq || ext_irq) |-> $past(cur.strobe) && $past(cur.mode) != MODE_STABILIZE;
	endproperty
	a_irq_strobe: assert property (p_irq_strobe) else $error("request off strobe");

	property p_stab_time;
		@(posedge clk) disable iff (!rst_sync_n)
		cur.mode == MODE_ACTIVE && $past(cur.mode) == MODE_STABILIZE |-> $past(cur.stab_cnt) == 20'(STAB_CYC - 1);
	endproperty
	a_stab_time: assert property (p_stab_time) else $error("active before stabilization");

	property p_watch_wake;
		@(posedge clk) disable iff (!rst_sync_n)
		cur.mode == MODE_WATCH && !cur.strobe |=> cur.mode == MODE_WATCH;
	endproperty
	a_watch_wake: assert property (p_watch_wake) else $error("watch left off strobe");
endmodule // low_power_mode_sequencer

/* File: sim/low_power_mode_sequencer_tb.sv */
// self-checking bench for the low-power mode sequencer
// assumes lpm_pkg and the design file are compiled first; the bench drives every port itself
`timescale 1ns/1ps
module low_power_mode_sequencer_tb
	import lpm_pkg::*;
;
	// ============================================================
	// signals
	localparam int STAB      = 20;
	localparam int SHORT     = 4;
	localparam int FRAME_CYC = FRAME_TICKS_0 * SUB_DIV_CYC;
	logic        clk                     = 1'b0;
	logic        rst_n                   = 1'b0;
	logic        hsel                    = 1'b0;
	logic [31:0] haddr                   = 32'h0;
	logic [1:0]  htrans                  = 2'h0;
	logic        hwrite                  = 1'b0;
	logic [31:0] hwdata                  = 32'h0;
	logic        stop_instr              = 1'b0;
	logic        standby_instr           = 1'b0;
	logic        global_interrupt_enable = 1'b1;
	logic        unmasked_irq_pending    = 1'b0;
	logic        ext_wake_interrupt_n    = 1'b1;
	logic        stop_cancel_pin_n       = 1'b1;
	ahb_in_s     bus_in;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	power_mode_e power_mode;
	logic        cpu_clk_en;
	logic        instr_tick;
	logic        cpu_restart;
	logic        main_osc_en;
	logic        timer_a_irq;
	logic        ext_irq;
	logic [63:0] notes[$];
	logic [63:0] note;
	logic        rd_dp = 1'b0;
	int          n_errors = 0;
	int          n_checks = 0;
	int          n;
	integer      seed = 32'hb0b1;
	logic [31:0] rnd;

	assign bus_in = {hsel, haddr, htrans, hwrite, 3'h2, hwdata, hreadyout};
	always #10 clk = ~clk;

	low_power_mode_sequencer #(.STAB_CYC(STAB), .LONG_CYC(8), .SHORT_CYC(SHORT)) u_low_power_mode_sequencer (
		.clk(clk), .rst_n(rst_n), .ahb_in(bus_in), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.stop_instr(stop_instr), .standby_instr(standby_instr),
		.global_interrupt_enable(global_interrupt_enable), .unmasked_irq_pending(unmasked_irq_pending),
		.ext_wake_interrupt_n(ext_wake_interrupt_n), .stop_cancel_pin_n(stop_cancel_pin_n),
		.power_mode(power_mode), .cpu_clk_en(cpu_clk_en), .instr_tick(instr_tick), .cpu_restart(cpu_restart),
		.main_osc_en(main_osc_en), .timer_a_irq(timer_a_irq), .ext_irq(ext_irq));

	// ============================================================
	// tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t %s: saw %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic final_report();
		if (n_errors == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// one single word transfer; address phase held until hready, then data phase held until hready
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {22'h0, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
	endtask

	task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic [31:0] msk);
		notes.push_back({msk, exp});
		bus(1'b0, idx, 32'h0);
	endtask

	task automatic pulse(input logic standby_instruction);
		@(posedge clk);
		stop_instr <= !standby_instruction;
		standby_instr <= standby_instruction;
		@(posedge clk);
		stop_instr <= 1'b0;
		standby_instr <= 1'b0;
	endtask

	// bounded wait; the watchdog still guards the run as a whole
	task automatic wait_mode(input power_mode_e m, input int lim, output int cyc);
		cyc = 0;
		while (power_mode !== m && cyc < lim) begin
			@(posedge clk);
			cyc++;
		end
		check({29'h0, power_mode}, {29'h0, m}, "mode reached");
	endtask

	task automatic do_reset();
		@(posedge clk);
		rst_n <= 1'b0;
		#1;
		check({29'h0, power_mode}, {29'h0, MODE_ACTIVE}, "async reset mode");
		check({31'h0, cpu_restart}, 32'h1, "restart during reset");
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		while (hreadyout !== 1'b1) @(posedge clk);
	endtask

	// ============================================================
	// monitor: the oldest note is compared with each read data phase
	always @(posedge clk) begin
		if (rd_dp && hreadyout === 1'b1) begin
			note = notes.pop_front();
			check(hrdata & note[63:32], note[31:0], "read data");
			check({31'h0, hresp}, 32'h0, "okay response");
		end
		if (hreadyout === 1'b1)
			rd_dp = hsel && htrans[1] && !hwrite;
	end

	initial begin
		repeat (80000) @(posedge clk);
		n_errors++;
		final_report();
	end

	// ============================================================
	// main sequence
	initial begin
		do_reset();
		rd(IDX_MODE_FLAGS, 32'h0, 32'hF);
		rd(IDX_RAM_FLAGS, 32'h0, 32'h8);
		rd(IDX_MISC, 32'h0, 32'hF);
		rd(IDX_SYS_CLK_SEL, 32'h0, 32'hE);
		rd(IDX_STATUS, {29'h0, MODE_ACTIVE}, 32'h7);
		bus(1'b1, 8'h10, 32'hF);
		rd(8'h10, 32'h0, 32'hFFFFFFFF);
		rnd = $random(seed);
		bus(1'b1, IDX_SYS_CLK_SEL, {28'h0, rnd[3], 1'b1, rnd[1], 1'b0});
		rd(IDX_SYS_CLK_SEL, {28'h0, rnd[3], 1'b1, rnd[1], 1'b0}, 32'hE);
		bus(1'b1, IDX_MISC, {28'h0, rnd[5], 3'h0});
		rd(IDX_MISC, {28'h0, rnd[5], 3'h0}, 32'hB);
		// direct-transfer write outside subactive must not stick
		bus(1'b1, IDX_MODE_FLAGS, 32'h9);
		rd(IDX_MODE_FLAGS, 32'h1, 32'h9);
		global_interrupt_enable <= 1'b0;
		unmasked_irq_pending <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			pulse(k[0]);
			rd(IDX_STATUS, {29'h0, MODE_ACTIVE}, 32'h7);
		end
		global_interrupt_enable <= 1'b1;
		unmasked_irq_pending <= 1'b0;
		pulse(1'b1);
		wait_mode(MODE_STANDBY, 10, n);
		#1;
		check({31'h0, cpu_clk_en}, 32'h0, "clock gated in standby");
		check({31'h0, main_osc_en}, 32'h1, "main oscillator runs in standby");
		@(posedge clk);
		unmasked_irq_pending <= 1'b1;
		wait_mode(MODE_ACTIVE, 10, n);
		unmasked_irq_pending <= 1'b0;
		stop_cancel_pin_n <= 1'b0;
		repeat (4) @(posedge clk);
		stop_cancel_pin_n <= 1'b1;
		rd(IDX_STATUS, {29'h0, MODE_ACTIVE}, 32'h7);
		rd(IDX_RAM_FLAGS, 32'h0, 32'h8);
		bus(1'b1, IDX_TIMER_A_MODE, 32'h0);
		pulse(1'b0);
		wait_mode(MODE_STOP, 10, n);
		stop_cancel_pin_n <= 1'b0;
		n = 0;
		while (cpu_restart !== 1'b1 && n < 10) begin
			@(posedge clk);
			n++;
		end
		check({31'h0, cpu_restart}, 32'h1, "restart on stop cancel");
		wait_mode(MODE_ACTIVE, STAB + 10, n);
		stop_cancel_pin_n <= 1'b1;
		rd(IDX_RAM_FLAGS, 32'h8, 32'h8);
		pulse(1'b0);
		wait_mode(MODE_STOP, 10, n);
		do_reset();
		rd(IDX_RAM_FLAGS, 32'h0, 32'h8);
		rd(IDX_MISC, 32'h0, 32'hF);
		// watch with low-speed set, woken by the external pin into subactive
		bus(1'b1, IDX_MODE_FLAGS, 32'h1);
		bus(1'b1, IDX_SYS_CLK_SEL, 32'h4);
		bus(1'b1, IDX_TIMER_A_MODE, 32'h8);
		pulse(1'b0);
		wait_mode(MODE_WATCH, 10, n);
		check({31'h0, main_osc_en}, 32'h0, "main oscillator off in watch");
		ext_wake_interrupt_n <= 1'b0;
		wait_mode(MODE_SUBACTIVE, 4 * FRAME_CYC, n);
		check({31'h0, ext_irq}, 32'h1, "external request on wake strobe");
		check({31'h0, timer_a_irq}, 32'h0, "no timer overflow yet");
		// cycle-time select of one gives the short instruction cycle
		n = 0;
		while (instr_tick !== 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		@(posedge clk);
		n = 1;
		while (instr_tick !== 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		check(n, SHORT, "instruction cycle");
		bus(1'b1, IDX_MODE_FLAGS, 32'h8);
		rd(IDX_MODE_FLAGS, 32'h8, 32'h9);
		ext_wake_interrupt_n <= 1'b1;
		pulse(1'b1);
		wait_mode(MODE_ACTIVE, FRAME_CYC + STAB + 10, n);
		check({31'h0, n > STAB}, 32'h1, "direct transfer too fast");
		check({31'h0, n <= FRAME_CYC + STAB + 2}, 32'h1, "direct transfer too slow");
		rd(IDX_MODE_FLAGS, 32'h0, 32'h9);
		repeat (4) @(posedge clk);
		final_report();
	end
endmodule // low_power_mode_sequencer_tb
